//--- hw/reset_ctl.sv
// Reset control, warm-up sequencing and reset cause flags
//
// The APB register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module reset_ctl (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_reset_pin_n,
	input wire logic flash_standby_reset,
	input wire logic trim_reset,
	input wire logic voltage_det2_reset,
	input wire logic voltage_det1_reset,
	input wire logic clock_fault_reset,
	input wire logic watchdog_reset,
	output logic cpu_reset_n,
	output logic periph_reset_n,
	output logic cpu_start,
	output logic [15:0] cpu_fetch_addr,
	output logic [7:0] trim_value,
	output logic vdet_disable,
	output logic ext_reset_disable_effective,
	output logic reset_area_effective,
	output logic reset_vector_effective
);
	reset_ctl_pkg::seq_state_t state;
	reset_ctl_pkg::seq_state_t next_state;
	logic ext_pin_sync_n;
	logic ext_active;
	logic internal_any;
	logic reset_hold;
	logic [2:0] ctl_reg;
	logic fclr_req;
	logic [6:0] flags;
	logic [6:0] flag_set;
	logic flag_clear;
	logic [11:0] warm_cnt;
	logic warm_done;
	logic trim_abnormal_evt;
	logic bus_wr;
	logic wr_control;
	logic wr_cause;
	logic wr_commit;
	logic commit_dis;
	logic commit_area_vec;
	logic commit_clear;
	logic addr_hit;
	logic [7:0] rd_byte;
	trim_if trim_port ();

	// External reset pin into the clock domain
	sync_2ff #(
		.WIDTH(1),
		.RESET_VAL(1'b1)
	) ext_pin_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.async_in(ext_reset_pin_n),
		.sync_out(ext_pin_sync_n)
	);

	// Trim store read during warm-up
	trim_store trim_mem (
		.mclk(mclk),
		.rst_n(rst_n),
		.port(trim_port.store)
	);

	assign ext_active = !ext_pin_sync_n && !ext_reset_disable_effective;

	// Any internal-factor reset source
	assign internal_any = flash_standby_reset | trim_reset | voltage_det2_reset
		| voltage_det1_reset | clock_fault_reset | watchdog_reset;

	// one reset from all sources; power-on acts through rst_n
	assign reset_hold = ext_active | internal_any;

	// APB decode; zero wait state
	assign bus_wr = psel && penable && pwrite;
	assign wr_control = bus_wr && (paddr == reset_ctl_pkg::CONTROL_ADDR);
	assign wr_cause = bus_wr && (paddr == reset_ctl_pkg::CAUSE_ADDR);
	// writes at the separate commit address go to commit
	assign wr_commit = bus_wr && (paddr == reset_ctl_pkg::COMMIT_ADDR);
	assign addr_hit = (paddr == reset_ctl_pkg::CAUSE_ADDR)
		|| (paddr == reset_ctl_pkg::CONTROL_ADDR)
		|| (paddr == reset_ctl_pkg::COMMIT_ADDR);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_hit;

	// commit code decode; other codes ignored
	assign commit_dis = wr_commit && (pwdata[7:0] == reset_ctl_pkg::CODE_EXT_DISABLE);
	assign commit_area_vec = wr_commit
		&& (pwdata[7:0] == reset_ctl_pkg::CODE_AREA_VECTOR);
	// clear needs request bit already set
	assign commit_clear = wr_commit && fclr_req
		&& (pwdata[7:0] == reset_ctl_pkg::CODE_FLAG_CLEAR);

	// Read mux
	always_comb begin
		rd_byte = 8'h00;
		case (paddr)
			reset_ctl_pkg::CONTROL_ADDR: begin
				rd_byte = {5'h00, ctl_reg};
			end
			reset_ctl_pkg::COMMIT_ADDR: begin
				rd_byte = {5'h00, reset_vector_effective, reset_area_effective,
					ext_reset_disable_effective};
			end
			reset_ctl_pkg::CAUSE_ADDR: begin
				rd_byte = {1'b0, flags};
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
	end

	// Read data captured in the setup cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= {24'h00_0000, rd_byte};
		end
	end

	// control register clears on any reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_reg <= reset_ctl_pkg::CTL_RESET;
		end else if (reset_hold) begin
			ctl_reg <= reset_ctl_pkg::CTL_RESET;
		end else if (wr_control) begin
			ctl_reg <= pwdata[2:0];
		end
	end

	// committed disable clears only on power-on
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ext_reset_disable_effective <= 1'b0;
		end else if (commit_dis) begin
			ext_reset_disable_effective <= ctl_reg[reset_ctl_pkg::CTL_EXT_DIS_BIT];
		end
	end

	// area and vector committed on code 0xD4
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reset_area_effective <= 1'b0;
			reset_vector_effective <= 1'b0;
		end else if (commit_area_vec) begin
			reset_area_effective <= ctl_reg[reset_ctl_pkg::CTL_AREA_BIT];
			reset_vector_effective <= ctl_reg[reset_ctl_pkg::CTL_VECTOR_BIT];
		end
	end

	// request bit cleared by its own commit
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fclr_req <= 1'b0;
		end else if (reset_hold || commit_clear) begin
			fclr_req <= 1'b0;
		end else if (wr_cause) begin
			fclr_req <= pwdata[reset_ctl_pkg::CAUSE_FCLR_BIT];
		end
	end

	// trim abnormal status on bit 5
	always_comb begin
		flag_set = 7'h00;
		flag_set[reset_ctl_pkg::CAUSE_FLASH_BIT] = flash_standby_reset;
		flag_set[reset_ctl_pkg::CAUSE_TRIM_ABNORMAL_STATUS_BIT] = trim_abnormal_evt;
		flag_set[reset_ctl_pkg::CAUSE_TRIM_BIT] = trim_reset;
		flag_set[reset_ctl_pkg::CAUSE_LVD2_BIT] = voltage_det2_reset;
		flag_set[reset_ctl_pkg::CAUSE_LVD1_BIT] = voltage_det1_reset;
		flag_set[reset_ctl_pkg::CAUSE_CLK_BIT] = clock_fault_reset;
		flag_set[reset_ctl_pkg::CAUSE_WDT_BIT] = watchdog_reset;
	end

	// external reset or committed clear; internal resets do not clear
	assign flag_clear = ext_active || commit_clear;

	// Sticky flags; a set in the clear cycle wins
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flags <= reset_ctl_pkg::FLAGS_RESET;
		end else begin
			flags <= flag_set | (flags & {7{!flag_clear}});
		end
	end

	// Sequencer next state
	always_comb begin
		next_state = state;
		case (state)
			reset_ctl_pkg::ST_HOLD: begin
				if (!reset_hold) begin
					next_state = reset_ctl_pkg::ST_WARMUP;
				end
			end
			reset_ctl_pkg::ST_WARMUP: begin
				if (reset_hold) begin
					next_state = reset_ctl_pkg::ST_HOLD;
				end else if (warm_done) begin
					next_state = reset_ctl_pkg::ST_RUN;
				end
			end
			reset_ctl_pkg::ST_RUN: begin
				if (reset_hold) begin
					next_state = reset_ctl_pkg::ST_HOLD;
				end
			end
			default: begin
				next_state = reset_ctl_pkg::ST_HOLD;
			end
		endcase
	end

	// State register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= reset_ctl_pkg::ST_HOLD;
		end else begin
			state <= next_state;
		end
	end

	// counter held in reset outside warm-up
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			warm_cnt <= 12'h000;
		end else if (state != reset_ctl_pkg::ST_WARMUP || reset_hold) begin
			warm_cnt <= 12'h000;
		end else if (!warm_done) begin
			warm_cnt <= warm_cnt + 12'h001;
		end
	end

	assign warm_done = (warm_cnt == reset_ctl_pkg::WARMUP_CYCLES - 12'h001);

	// read two trim words at warm-up start
	assign trim_port.rd_en = (state == reset_ctl_pkg::ST_WARMUP) && !reset_hold
		&& (warm_cnt < 12'h002);
	assign trim_port.addr = warm_cnt[0];

	// capture trim value from word 0
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			trim_value <= reset_ctl_pkg::TRIM_DEFAULT;
		end else if (state == reset_ctl_pkg::ST_WARMUP && !reset_hold
			&& warm_cnt == 12'h001) begin
			trim_value <= trim_port.rd_data;
		end
	end

	// one-cycle event when word 1 is not the complement of word 0
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			trim_abnormal_evt <= 1'b0;
		end else begin
			trim_abnormal_evt <= (state == reset_ctl_pkg::ST_WARMUP) && !reset_hold
				&& (warm_cnt == 12'h002) && (trim_port.rd_data != ~trim_value);
		end
	end

	// cpu held through warm-up, peripherals only while a source acts
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_reset_n <= 1'b0;
			periph_reset_n <= 1'b0;
		end else begin
			cpu_reset_n <= (next_state == reset_ctl_pkg::ST_RUN);
			periph_reset_n <= (next_state != reset_ctl_pkg::ST_HOLD);
		end
	end

	// one-cycle start pulse as warm-up ends
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_start <= 1'b0;
		end else begin
			cpu_start <= (state == reset_ctl_pkg::ST_WARMUP)
				&& (next_state == reset_ctl_pkg::ST_RUN);
		end
	end

	// fixed vector location for the first fetch
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_fetch_addr <= reset_ctl_pkg::RESET_VECTOR_ADDR;
		end else begin
			cpu_fetch_addr <= reset_ctl_pkg::RESET_VECTOR_ADDR;
		end
	end

	// detectors disabled by external or power-on reset only
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			vdet_disable <= 1'b1;
		end else begin
			vdet_disable <= ext_active;
		end
	end
endmodule
`default_nettype wire

//--- hw/reset_ctl_pkg.sv
// Constants and types shared by the reset control block
package reset_ctl_pkg;
	// Printed register indices; the byte address is four times the index
	localparam logic [15:0] CAUSE_INDEX = 16'h0fcc;
	localparam logic [15:0] CONTROL_INDEX = 16'h0fde;
	localparam logic [15:0] COMMIT_INDEX = 16'h0fdf;
	localparam logic [15:0] CAUSE_ADDR = {CAUSE_INDEX[13:0], 2'h0};
	localparam logic [15:0] CONTROL_ADDR = {CONTROL_INDEX[13:0], 2'h0};
	localparam logic [15:0] COMMIT_ADDR = {COMMIT_INDEX[13:0], 2'h0};

	// Commit codes
	localparam logic [7:0] CODE_EXT_DISABLE = 8'hb2;
	localparam logic [7:0] CODE_AREA_VECTOR = 8'hd4;
	localparam logic [7:0] CODE_FLAG_CLEAR = 8'h71;

	// Reset control register fields
	localparam int CTL_EXT_DIS_BIT = 0;
	localparam int CTL_AREA_BIT = 1;
	localparam int CTL_VECTOR_BIT = 2;
	localparam int CTL_WIDTH = 3;
	localparam logic [2:0] CTL_RESET = 3'h0;

	// Reset cause register fields
	localparam int CAUSE_FCLR_BIT = 7;
	localparam int CAUSE_FLASH_BIT = 6;
	localparam int CAUSE_TRIM_ABNORMAL_STATUS_BIT = 5;
	localparam int CAUSE_TRIM_BIT = 4;
	localparam int CAUSE_LVD2_BIT = 3;
	localparam int CAUSE_LVD1_BIT = 2;
	localparam int CAUSE_CLK_BIT = 1;
	localparam int CAUSE_WDT_BIT = 0;
	localparam logic [6:0] FLAGS_RESET = 7'h00;

	// Warm-up timing at the 50 ns clock, least time rounded up
	localparam int CLK_PERIOD_NS = 50;
	localparam int WARMUP_TIME_NS = 200000;
	localparam int WARMUP_CYCLES_INT = (WARMUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [11:0] WARMUP_CYCLES = WARMUP_CYCLES_INT[11:0];

	// Reset vector location fetched by the CPU
	localparam logic [15:0] RESET_VECTOR_ADDR = 16'hfffe;

	// Trim store: word 0 trim value, word 1 its complement
	localparam logic [7:0] TRIM_DEFAULT = 8'h5a;

	typedef enum logic [1:0] {
		ST_HOLD = 2'h0,
		ST_WARMUP = 2'h1,
		ST_RUN = 2'h3
	} seq_state_t;
endpackage

//--- hw/trim_if.sv
// Read port between the trim loader and the trim store
`timescale 1ns/100ps
`default_nettype none
interface trim_if;
	logic rd_en;
	logic addr;
	logic [7:0] rd_data;
	modport loader (output rd_en, output addr, input rd_data);
	modport store (input rd_en, input addr, output rd_data);
endinterface
`default_nettype wire

//--- hw/sync_2ff.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module sync_2ff #(
	parameter int WIDTH = 1,
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	// First stage feeds only the second
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= {WIDTH{RESET_VAL}};
			sync_out <= {WIDTH{RESET_VAL}};
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule
`default_nettype wire

//--- hw/trim_store.sv
// Non-volatile trim store with registered read data
`timescale 1ns/100ps
`default_nettype none
module trim_store (
	input wire logic mclk,
	input wire logic rst_n,
	trim_if.store port
);
	logic [7:0] rom [0:1];

	// Fixed contents: value then complement
	assign rom[0] = reset_ctl_pkg::TRIM_DEFAULT;
	assign rom[1] = ~reset_ctl_pkg::TRIM_DEFAULT;

	// Registered read
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			port.rd_data <= 8'h00;
		end else if (port.rd_en) begin
			port.rd_data <= rom[port.addr];
		end
	end
endmodule
`default_nettype wire

//--- test/reset_ctl_asserts.sv
// Port-level checker for the reset control block
`timescale 1ns/100ps
`default_nettype none
module reset_ctl_asserts (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic ext_reset_pin_n,
	input wire logic flash_standby_reset,
	input wire logic trim_reset,
	input wire logic voltage_det2_reset,
	input wire logic voltage_det1_reset,
	input wire logic clock_fault_reset,
	input wire logic watchdog_reset,
	input wire logic cpu_reset_n,
	input wire logic periph_reset_n,
	input wire logic cpu_start,
	input wire logic [15:0] cpu_fetch_addr,
	input wire logic vdet_disable,
	input wire logic ext_reset_disable_effective,
	input wire logic reset_area_effective,
	input wire logic reset_vector_effective
);
	logic any_src;
	logic acc;
	// Decoded helpers
	assign any_src = flash_standby_reset | trim_reset | voltage_det2_reset | voltage_det1_reset
		| clock_fault_reset | watchdog_reset;
	assign acc = psel & penable;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	commit_only_a: assert property (!(acc && pwrite && paddr == reset_ctl_pkg::COMMIT_ADDR) |=>
		$stable({ext_reset_disable_effective, reset_area_effective, reset_vector_effective}))
		else $error("committed bits moved without a commit write");
	status_read_a: assert property (acc && !pwrite && paddr == reset_ctl_pkg::COMMIT_ADDR |->
		prdata[2:0] == {reset_vector_effective, reset_area_effective, ext_reset_disable_effective})
		else $error("status read differs from committed bits");
	ctl_upper_a: assert property (acc && !pwrite && paddr == reset_ctl_pkg::CONTROL_ADDR |->
		prdata[7:3] == 5'h00) else $error("control upper bits not zero");
	clear_bit_a: assert property (acc && !pwrite && paddr == reset_ctl_pkg::CAUSE_ADDR |->
		!prdata[7]) else $error("clear request reads one");
	hold_reset_a: assert property (any_src |-> ##[1:3] (!cpu_reset_n && !periph_reset_n))
		else $error("source did not hold cpu and peripherals");
	warm_hold_a: assert property ($rose(periph_reset_n) |-> !cpu_reset_n [*8])
		else $error("cpu released without warm-up");
	start_vec_a: assert property ($rose(cpu_reset_n) |-> cpu_start && cpu_fetch_addr == 16'hfffe)
		else $error("start without pulse or wrong vector");
	pin_blocked_a: assert property (cpu_reset_n && ext_reset_disable_effective && !any_src
		|=> cpu_reset_n) else $error("blocked pin reset the cpu");
	vdet_cause_a: assert property ($rose(vdet_disable) |-> !$past(ext_reset_pin_n, 2)
		|| !$past(ext_reset_pin_n, 3) || !$past(ext_reset_pin_n, 4))
		else $error("detector disabled without pin reset");
	slverr_phase_a: assert property (pslverr |-> acc) else $error("slave error outside access");
	cover property (cpu_start);
	cover property (pslverr);
	cover property (acc && pwrite && pwdata[7:0] == reset_ctl_pkg::CODE_FLAG_CLEAR);
endmodule
bind reset_ctl reset_ctl_asserts u_chk (.*);
`default_nettype wire

//--- test/reset_src_model.sv
// Far-side reset sources: six internal factors and the external pin
`timescale 1ns/100ps
`default_nettype none
module reset_src_model (
	input wire logic [2:0] src,
	input wire logic go,
	output logic flash_standby_reset,
	output logic trim_reset,
	output logic voltage_det2_reset,
	output logic voltage_det1_reset,
	output logic clock_fault_reset,
	output logic watchdog_reset,
	output logic ext_reset_pin_n
);
	// One source at a time; index 6 pulls the pin low, else it idles high
	assign {flash_standby_reset, trim_reset, voltage_det2_reset, voltage_det1_reset,
		clock_fault_reset, watchdog_reset} = go ? (6'h01 << src) : 6'h00;
	assign ext_reset_pin_n = !(go && src == 3'h6);
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the reset control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam logic [15:0] a_cause = reset_ctl_pkg::CAUSE_ADDR;
	localparam logic [15:0] a_ctl = reset_ctl_pkg::CONTROL_ADDR;
	localparam logic [15:0] a_cmt = reset_ctl_pkg::COMMIT_ADDR;
	localparam int w = reset_ctl_pkg::WARMUP_CYCLES_INT;
	logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, go = 0, serr, vd;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000, rdat, d;
	logic [2:0] src = 3'h0;
	wire logic [31:0] prdata;
	wire logic [15:0] cpu_fetch_addr;
	wire logic [7:0] trim_value;
	wire logic pready, pslverr, cpu_reset_n, periph_reset_n, cpu_start, vdet_disable;
	wire logic ext_reset_disable_effective, reset_area_effective, reset_vector_effective;
	wire logic flash_standby_reset, trim_reset, voltage_det2_reset, voltage_det1_reset;
	wire logic clock_fault_reset, watchdog_reset, ext_reset_pin_n;
	int err_total = 0, n_compared = 0, seed = 18, eff = 0, flags = 0, ctl;
	int since_rel = 0;
	reset_ctl u_dut (.*);
	reset_src_model u_src (.*);
	// Clock at 50 ns
	always #25 mclk = ~mclk;
	// Edges since the peripherals last left reset; warm-up is timed from here
	always @(posedge mclk) begin
		if (periph_reset_n !== 1'b1) begin
			since_rel <= 0;
		end else begin
			since_rel <= since_rel + 1;
		end
	end
	task automatic end_sim();
		$display("TB: errors %0d, checks %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// plain whole-word transfers, never a read-modify-write of the commit register
	task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] dat);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dat;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [15:0] a, input int exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdat, exp);
	endtask
	// Assert one source for len cycles, noting the detector disable on the way
	task automatic fire(input int s, input int len);
		src <= s[2:0];
		go <= 1'b1;
		repeat (len) @(posedge mclk);
		vd = vdet_disable;
		go <= 1'b0;
		@(posedge mclk);
	endtask
	// Wait for the start pulse, then check the edges counted since release
	task automatic wait_run();
		int n;
		n = 0;
		while (periph_reset_n !== 1'b1 && n < 50) begin
			@(posedge mclk);
			n++;
		end
		n = 0;
		while (cpu_start !== 1'b1 && n < w + 50) begin
			@(posedge mclk);
			n++;
		end
		chk(since_rel >= w - 1 && since_rel <= w + 1, 1);
		chk(cpu_fetch_addr, 16'hfffe);
	endtask
	// Watchdog on the whole run
	initial begin
		#4_000_000;
		err_total++;
		$display("BAD t=%0t timeout", $time);
		end_sim();
	end
	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		rd(a_cause, 0);
		rd(a_ctl, 0);
		rd(a_cmt, 0);
		chk(cpu_reset_n, 0);
		chk(periph_reset_n, 1);
		wait_run();
		chk(trim_value, 8'h5a);
		rd(16'h0100, 0);
		chk(serr, 1);
		d = $random(seed);
		apb(1'b1, a_ctl, d);
		ctl = d[2:0];
		rd(a_ctl, ctl);
		for (int i = 0; i < 4; i++) begin
			d = $random(seed);
			if (d[7:0] == 8'hb2 || d[7:0] == 8'hd4 || d[7:0] == 8'h71) d = 32'h0000_0000;
			apb(1'b1, a_cmt, d);
			rd(a_cmt, eff);
		end
		apb(1'b1, a_cmt, 32'h0000_00b2);
		eff = (eff & 6) | (ctl & 1);
		rd(a_cmt, eff);
		apb(1'b1, a_cmt, 32'h0000_00d4);
		eff = (eff & 1) | (ctl & 6);
		rd(a_cmt, eff);
		chk({reset_vector_effective, reset_area_effective, ext_reset_disable_effective}, eff);
		apb(1'b1, a_ctl, 32'h0000_0001);
		apb(1'b1, a_cmt, 32'h0000_00b2);
		eff = eff | 1;
		fire(6, 10);
		repeat (8) @(posedge mclk);
		chk(cpu_reset_n, 1);
		fire(0, 5);
		repeat (200) @(posedge mclk);
		for (int i = 0; i < 6; i++) begin
			fire(i, 5);
			flags = flags | ((i == 5) ? 32'h40 : (1 << i));
			chk(vd, 0);
			rd(a_ctl, 0);
			rd(a_cmt, eff);
			rd(a_cause, flags);
			wait_run();
		end
		apb(1'b1, a_ctl, 32'h0000_0000);
		apb(1'b1, a_cmt, 32'h0000_00b2);
		eff = eff & 6;
		fire(6, 10);
		chk(vd, 1);
		rd(a_cause, 0);
		rd(a_cmt, eff);
		wait_run();
		fire(0, 5);
		apb(1'b1, a_cause, 32'h0000_0080);
		rd(a_cause, 1);
		apb(1'b1, a_cmt, 32'h0000_0071);
		rd(a_cause, 0);
		wait_run();
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		rd(a_cmt, 0);
		chk({reset_vector_effective, reset_area_effective, ext_reset_disable_effective}, 0);
		wait_run();
		end_sim();
	end
endmodule
`default_nettype wire
